/* bench/lcd_host_register_port_tb.sv */
/*
 Self-checking bench of the display host port: register table, pointer, layouts, 4-bit, reset.
 Assumes lhp_host as the processor and a 20 MHz clock.
*/
`timescale 1ns/1ns
module lcd_host_register_port_tb;
    import lhp_pkg::*;
    typedef struct packed {logic rs; logic rw; logic poll; logic [7:0] d; logic [7:0] exp;} lhp_row_t;
    logic clk_sys, rstn, rst_pin_n, host_strobe, register_select, read_write;
    logic busy_flag, line_count_select, split_index;
    logic [7:0] sample, drive, en, q;
    lhp_ptr_t line0_start, line1_start;
    int mismatches = 0;
    int checks = 0;
    // Columns: select, read, poll first, data, expected read
    lhp_row_t rows [0:24] = '{
        '{1'b0, 1'b0, 1'b1, 8'h83, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'h41, 8'h00},
        '{1'b1, 1'b0, 1'b1, 8'h42, 8'h00}, '{1'b0, 1'b1, 1'b1, 8'h00, 8'h05},
        '{1'b0, 1'b0, 1'b1, 8'h83, 8'h00}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'h41},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h42}, '{1'b0, 1'b1, 1'b1, 8'h00, 8'h05},
        '{1'b0, 1'b0, 1'b1, 8'h04, 8'h00}, '{1'b0, 1'b0, 1'b1, 8'h80, 8'h00},
        '{1'b1, 1'b0, 1'b1, 8'h55, 8'h00}, '{1'b0, 1'b1, 1'b1, 8'h00, 8'h0F},
        '{1'b0, 1'b0, 1'b1, 8'h06, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'h66, 8'h00},
        '{1'b0, 1'b1, 1'b1, 8'h00, 8'h00}, '{1'b0, 1'b0, 1'b1, 8'h8F, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h66}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'h55},
        '{1'b0, 1'b0, 1'b1, 8'h80, 8'h00}, '{1'b1, 1'b0, 1'b1, 8'hAA, 8'h00},
        '{1'b1, 1'b0, 1'b0, 8'hBB, 8'h00}, '{1'b0, 1'b1, 1'b0, 8'h00, 8'h81},
        '{1'b0, 1'b0, 1'b1, 8'h80, 8'h00}, '{1'b1, 1'b1, 1'b1, 8'h00, 8'hAA},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h20}};

    lhp_port #(.BUSY_CYC(40), .RST_HOLD_CYC(20)) i_lhp_port (
        .clk_sys(clk_sys), .rstn(rstn), .rst_pin_n(rst_pin_n), .host_strobe(host_strobe),
        .register_select(register_select), .read_write(read_write),
        .host_bus_lines_sample(sample), .host_bus_lines_drive(drive), .host_bus_lines_en(en),
        .busy_flag(busy_flag), .line_count_select(line_count_select),
        .split_index(split_index), .line0_start(line0_start), .line1_start(line1_start));

    lhp_host i_lhp_host (
        .clk_sys(clk_sys), .host_strobe(host_strobe), .register_select(register_select),
        .read_write(read_write), .host_bus_lines_drive(drive), .host_bus_lines_en(en),
        .host_bus_lines_sample(sample));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic instr(input logic [7:0] d);
        logic [7:0] r;
        i_lhp_host.ready();
        i_lhp_host.xfer(1'b0, 1'b0, d, r);
        i_lhp_host.ready();
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        rst_pin_n = 1'b1;
        repeat (16) @(posedge clk_sys);
        #5;
        rstn = 1'b1;
        for (int i = 0; i < 25; i++) begin
            if (rows[i].poll) i_lhp_host.ready();
            i_lhp_host.xfer(rows[i].rs, rows[i].rw, rows[i].d, q);
            if (rows[i].rw) chk(q, rows[i].exp);
            chk(en, 8'h00);
        end
        $display("register table test done");
        instr(8'h1C);
        chk({1'b0, line0_start}, 8'h0F);
        chk({1'b0, line1_start}, 8'h07);
        instr(8'h18);
        instr(8'h18);
        chk({1'b0, line0_start}, 8'h01);
        chk({1'b0, line1_start}, 8'h09);
        instr(8'h1C);
        instr(8'h34);
        chk({7'h00, split_index}, 8'h01);
        chk({1'b0, line0_start}, 8'h00);
        chk({1'b0, line1_start}, 8'h40);
        instr(8'h1C);
        chk({1'b0, line0_start}, 8'h47);
        chk({1'b0, line1_start}, 8'h07);
        instr(8'h3C);
        chk({7'h00, line_count_select}, 8'h01);
        chk({7'h00, busy_flag}, 8'h00);
        $display("layout test done");
        instr(8'h43);
        i_lhp_host.xfer(1'b1, 1'b0, 8'hFF, q);
        i_lhp_host.ready();
        i_lhp_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h04);
        instr(8'h43);
        i_lhp_host.xfer(1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h1F);
        $display("glyph test done");
        i_lhp_host.ready();
        i_lhp_host.xfer(1'b0, 1'b0, 8'h20, q);
        // Single status polls would split nibble pairs here, so wait out busy instead
        repeat (50) @(posedge clk_sys);
        i_lhp_host.xfer(1'b0, 1'b0, 8'h80, q);
        i_lhp_host.xfer(1'b0, 1'b0, 8'h50, q);
        chk({7'h00, busy_flag}, 8'h01);
        repeat (50) @(posedge clk_sys);
        i_lhp_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk({4'h0, q[7:4]}, 8'h00);
        i_lhp_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk({4'h0, q[7:4]}, 8'h05);
        $display("nibble test done");
        @(posedge clk_sys);
        #5;
        rst_pin_n = 1'b0;
        repeat (40) @(posedge clk_sys);
        #5;
        rst_pin_n = 1'b1;
        repeat (10) @(posedge clk_sys);
        i_lhp_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h00);
        chk({1'b0, line1_start}, 8'h08);
        $display("pin reset test done");
        test_done();
    end
endmodule

/* bench/lhp_host.sv */
/*
 Processor model for the display host port: strobed register accesses and status polling.
 Assumes the port's split data lines; lines the port does not drive show the host value.
*/
`timescale 1ns/1ns
module lhp_host (
    // Clock
    input wire logic clk_sys,
    // Strobe and selects
    output logic host_strobe,
    output logic register_select,
    output logic read_write,
    // Data lines
    input wire logic [7:0] host_bus_lines_drive,
    input wire logic [7:0] host_bus_lines_en,
    output logic [7:0] host_bus_lines_sample
);
    logic [7:0] host_val;

    // Released lines flip on every read so stale data never looks valid
    assign host_bus_lines_sample = (host_bus_lines_en & host_bus_lines_drive) |
                                   (~host_bus_lines_en & host_val);

    initial begin
        host_strobe = 1'b0;
        register_select = 1'b0;
        read_write = 1'b1;
        host_val = 8'h5A;
    end

    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_sys);
        #5;
        register_select = rs;
        read_write = rw;
        host_val = rw ? ~host_val : d;
        host_strobe = 1'b1;
        repeat (8) @(posedge clk_sys);
        #5;
        q = host_bus_lines_sample;
        host_strobe = 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic ready();
        logic [7:0] q;
        for (int i = 0; i < 30; i++) begin
            xfer(1'b0, 1'b1, 8'h00, q);
            if (q[7] === 1'b0) break;
        end
    endtask
endmodule

/* hdl/lhp_cfg.svh */
/*
 Offsets, field positions, reset values and timing counts of the display host port.
 Assumes a 20 MHz system clock; included by the port module only, not by the package.
*/
`ifndef LHP_CFG_SVH
`define LHP_CFG_SVH

// Clock and timing
`define LHP_CLK_KHZ 20000
`define LHP_BUSY_NS 2000
`define LHP_BUSY_CYC ((`LHP_BUSY_NS * `LHP_CLK_KHZ + 999999) / 1000000)
`define LHP_RST_HOLD_US 1200
`define LHP_RST_HOLD_CYC ((`LHP_RST_HOLD_US * `LHP_CLK_KHZ + 999) / 1000)

// Instruction opcode bits
`define LHP_OP_TEXT_BIT 7
`define LHP_OP_GLYPH_BIT 6
`define LHP_OP_FUNC_BIT 5
`define LHP_OP_SHIFT_BIT 4
`define LHP_OP_ENTRY_BIT 2

// Instruction argument bits
`define LHP_FN_WIDE_BIT 4
`define LHP_FN_LINES_BIT 3
`define LHP_FN_SPLIT_BIT 2
`define LHP_EN_UP_BIT 1
`define LHP_SH_DISP_BIT 3
`define LHP_SH_RIGHT_BIT 2

// Status word layout
`define LHP_BUSY_BIT 7

// Address pointer landmarks
`define LHP_LIN_LAST 7'h0F
`define LHP_SPL_FRONT_LAST 7'h07
`define LHP_SPL_BACK_FIRST 7'h40
`define LHP_SPL_LAST 7'h47
`define LHP_HALF_OFS 4'h8

// Reset values
`define LHP_RST_WIDE 1'b1
`define LHP_RST_UP 1'b1
`define LHP_RST_CHAR 8'h20

`endif

/* hdl/lhp_pkg.sv */
/*
 Types of the display host port.
 Assumes nothing from lhp_cfg.svh; the command codes are defined here.
*/
package lhp_pkg;
    typedef enum logic [2:0] {
        LHP_CMD_NONE = 3'h0,
        LHP_CMD_TEXT = 3'h1,
        LHP_CMD_GLYPH = 3'h2,
        LHP_CMD_FUNC = 3'h3,
        LHP_CMD_SHIFT = 3'h4,
        LHP_CMD_ENTRY = 3'h5
    } lhp_cmd_t;
    typedef logic [6:0] lhp_ptr_t;
endpackage

/* hdl/lhp_port.sv */
/*
 Host register port of a character display controller: strobed 4/8-bit bus,
 instruction and data holding registers, address pointer, text and glyph memory.
 Assumes host pins arrive asynchronously and a 20 MHz clock with synchronous reset.
*/
`timescale 1ns/1ns
`include "lhp_cfg.svh"

// Operation
// - Two 8-bit host registers: instruction and data holding.
// - Instruction register is write-only; no read returns it.
// - Data writes land in the selected text or glyph memory location.
// - Setting an address prefetches that memory byte into the data register.
// - After each data read the next address's byte is prefetched.
// - Select and read/write pick instruction, status, data write or data read.
// - Register select alone picks instruction path or data path.
// - Busy flag reads 1 on bit 7 during internal work; host held off.
// - Address instruction loads pointer and picks text or glyph memory.
// - Pointer steps by one up or down after every data access.
// - Status read shows pointer on bits 6 to 0 beside busy.
// - Text memory holds 16 character codes of 8 bits.
// - Pointer is 7 bits: high digit bits 6-4, low digit bits 3-0.
// - Split-index bit from function set picks layout one or two.
// - Layout one maps the 16 positions to addresses 00-0F.
// - Layout two uses 00-07 then 40-47, wrapping 47 to 00.
// - Line-count bit from function set: 0 one line, 1 two lines.
// - Layout one shifts: left starts at 01, right starts at 0F.
// - Layout two: positions 1-8 at addresses 00-07, 9-16 at 40-47.
// - In 4-bit mode only the upper four lines carry data.
// - Reset pin low longer than 1.2 ms resets the logic.
module lhp_port #(
    parameter int unsigned BUSY_CYC = `LHP_BUSY_CYC,
    parameter int unsigned RST_HOLD_CYC = `LHP_RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic rst_pin_n,
    // Host strobe and selects
    input wire logic host_strobe,
    input wire logic register_select,
    input wire logic read_write,
    // Host data lines
    input wire logic [7:0] host_bus_lines_sample,
    output logic [7:0] host_bus_lines_drive,
    output logic [7:0] host_bus_lines_en,
    // Display state
    output logic busy_flag,
    output logic line_count_select,
    output logic split_index,
    output lhp_pkg::lhp_ptr_t line0_start,
    output lhp_pkg::lhp_ptr_t line1_start
);
    import lhp_pkg::*;

    localparam int unsigned SYNC_W = 12;

    // Pin synchronisers
    logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
    logic strobe_f_q, rst_f_q;
    logic [15:0] rst_cnt_q;
    logic soft_rst_q;
    // Core state
    logic wide_q, nib_q, up_q, glyph_sel_q, split_q, lines_q, busy_q;
    logic [3:0] hi_nib_q;
    lhp_ptr_t ptr_q;
    logic [7:0] dhr_q;
    logic [3:0] shift_q;
    logic [7:0] busy_cnt_q;
    logic [7:0] text_q [16];
    logic [4:0] glyph_q [32];
    logic [7:0] drive_q, oe_q;
    lhp_ptr_t line0_q, line1_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            // Idle pin levels: reset pin high, strobe low, so no false edge follows reset
            sync1_q <= {1'b1, 11'h000};
            sync2_q <= {1'b1, 11'h000};
            sync3_q <= {1'b1, 11'h000};
        end else begin
            sync1_q <= {rst_pin_n, host_strobe, register_select, read_write,
                        host_bus_lines_sample};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Filtered levels: a change counts once stages two and three agree
    wire strobe_ok = sync2_q[10] == sync3_q[10];
    wire rst_ok = sync2_q[11] == sync3_q[11];
    wire rs_s = sync3_q[9];
    wire rw_s = sync3_q[8];
    wire [7:0] bus_s = sync3_q[7:0];
    wire strobe_fall = strobe_f_q && strobe_ok && !sync3_q[10];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            strobe_f_q <= 1'b0;
            rst_f_q <= 1'b1;
        end else begin
            if (strobe_ok) strobe_f_q <= sync3_q[10];
            if (rst_ok) rst_f_q <= sync3_q[11];
        end
    end

    // Long-low reset pin
    always_ff @(posedge clk_sys) begin
        if (!rstn || rst_f_q) begin
            rst_cnt_q <= '0;
            soft_rst_q <= 1'b0;
        end else begin
            if (rst_cnt_q < 16'(RST_HOLD_CYC)) rst_cnt_q <= rst_cnt_q + 16'h1;
            soft_rst_q <= rst_cnt_q >= 16'(RST_HOLD_CYC);
        end
    end

    wire rst_all = !rstn || soft_rst_q;

    // Access completion; narrow mode needs two nibbles, high first
    wire done = strobe_fall && (wide_q || nib_q);
    wire [7:0] host_byte = wide_q ? bus_s : {hi_nib_q, bus_s[7:4]};
    wire wr_cmd = done && !rw_s && !rs_s && !busy_q;
    wire wr_dat = done && !rw_s && rs_s && !busy_q;
    wire rd_dat = done && rw_s && rs_s && !busy_q;
    wire busy_start = wr_cmd || wr_dat || rd_dat;

    lhp_cmd_t cmd;
    assign cmd = !wr_cmd ? LHP_CMD_NONE :
        host_byte[`LHP_OP_TEXT_BIT] ? LHP_CMD_TEXT :
        host_byte[`LHP_OP_GLYPH_BIT] ? LHP_CMD_GLYPH :
        host_byte[`LHP_OP_FUNC_BIT] ? LHP_CMD_FUNC :
        host_byte[`LHP_OP_SHIFT_BIT] ? LHP_CMD_SHIFT :
        host_byte[`LHP_OP_ENTRY_BIT] ? LHP_CMD_ENTRY : LHP_CMD_NONE;

    // Pointer stepping for each layout
    function automatic lhp_ptr_t step_ptr(lhp_ptr_t p, logic up, logic spl, logic gly);
        lhp_ptr_t r;
        r = p;
        if (gly) begin
            r = {2'h0, up ? p[4:0] + 5'h1 : p[4:0] - 5'h1};
        end else if (!spl) begin
            r = {3'h0, up ? p[3:0] + 4'h1 : p[3:0] - 4'h1};
        end else if (up) begin
            r = (p == `LHP_SPL_FRONT_LAST) ? `LHP_SPL_BACK_FIRST :
                (p == `LHP_SPL_LAST) ? 7'h00 : p + 7'h01;
        end else begin
            r = (p == 7'h00) ? `LHP_SPL_LAST :
                (p == `LHP_SPL_BACK_FIRST) ? `LHP_SPL_FRONT_LAST : p - 7'h01;
        end
        return r;
    endfunction

    // Display position to text address
    function automatic lhp_ptr_t pos_addr(logic [3:0] pos, logic spl);
        return spl ? {pos[3], 3'h0, pos[2:0]} : {3'h0, pos};
    endfunction

    // Next pointer and memory select
    wire glyph_d = (cmd == LHP_CMD_GLYPH) ? 1'b1 :
        (cmd == LHP_CMD_TEXT) ? 1'b0 : glyph_sel_q;
    lhp_ptr_t ptr_d;
    assign ptr_d = (cmd == LHP_CMD_TEXT) ? host_byte[6:0] :
        (cmd == LHP_CMD_GLYPH) ? {2'h0, host_byte[4:0]} :
        (wr_dat || rd_dat) ? step_ptr(ptr_q, up_q, split_q, glyph_sel_q) : ptr_q;

    // Memory index: layout two folds 40-47 onto entries 8-15
    wire [3:0] tidx_q = split_q ? {ptr_q[6], ptr_q[2:0]} : ptr_q[3:0];
    wire [3:0] tidx_d = split_q ? {ptr_d[6], ptr_d[2:0]} : ptr_d[3:0];
    wire [7:0] fetch_byte = glyph_d ? {3'h0, glyph_q[ptr_d[4:0]]} : text_q[tidx_d];
    wire fetch = (cmd == LHP_CMD_TEXT) || (cmd == LHP_CMD_GLYPH) || rd_dat;

    // Display shift
    wire shift_disp = (cmd == LHP_CMD_SHIFT) && host_byte[`LHP_SH_DISP_BIT];
    wire [3:0] shift_d = !shift_disp ? shift_q :
        host_byte[`LHP_SH_RIGHT_BIT] ? shift_q - 4'h1 : shift_q + 4'h1;
    wire split_d = (cmd == LHP_CMD_FUNC) ? host_byte[`LHP_FN_SPLIT_BIT] : split_q;

    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            wide_q <= `LHP_RST_WIDE;
            up_q <= `LHP_RST_UP;
            split_q <= 1'b0;
            lines_q <= 1'b0;
            glyph_sel_q <= 1'b0;
            ptr_q <= '0;
            shift_q <= '0;
        end else begin
            ptr_q <= ptr_d;
            glyph_sel_q <= glyph_d;
            shift_q <= shift_d;
            split_q <= split_d;
            if (cmd == LHP_CMD_FUNC) begin
                wide_q <= host_byte[`LHP_FN_WIDE_BIT];
                lines_q <= host_byte[`LHP_FN_LINES_BIT];
            end
            if (cmd == LHP_CMD_ENTRY) up_q <= host_byte[`LHP_EN_UP_BIT];
        end
    end

    // Data holding register: host writes or prefetch
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            dhr_q <= '0;
        end else if (wr_dat) begin
            dhr_q <= host_byte;
        end else if (fetch) begin
            dhr_q <= fetch_byte;
        end
    end

    // Nibble phase and busy timer
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            nib_q <= 1'b0;
            hi_nib_q <= '0;
            busy_cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            if (strobe_fall && !wide_q) begin
                nib_q <= !nib_q;
                if (!nib_q) hi_nib_q <= bus_s[7:4];
            end
            busy_cnt_q <= busy_start ? 8'(BUSY_CYC) :
                (busy_cnt_q != 8'h0) ? busy_cnt_q - 8'h1 : 8'h0;
            busy_q <= busy_start || (busy_cnt_q > 8'h1);
        end
    end

    // Memory storage, one writer per entry
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_text
            always_ff @(posedge clk_sys) begin
                if (rst_all) text_q[gi] <= `LHP_RST_CHAR;
                else if (wr_dat && !glyph_sel_q && tidx_q == 4'(gi))
                    text_q[gi] <= host_byte;
            end
        end
        for (gi = 0; gi < 32; gi++) begin : g_glyph
            always_ff @(posedge clk_sys) begin
                if (rst_all) glyph_q[gi] <= '0;
                else if (wr_dat && glyph_sel_q && ptr_q[4:0] == 5'(gi))
                    glyph_q[gi] <= host_byte[4:0];
            end
        end
    endgenerate

    // Read path: status word never shows the instruction register
    wire [7:0] status_word = {busy_q, ptr_q};
    wire [7:0] rd_word = rs_s ? dhr_q : status_word;
    wire [7:0] drive_d = wide_q ? rd_word :
        (nib_q ? {rd_word[3:0], 4'h0} : {rd_word[7:4], 4'h0});
    wire rd_cycle = strobe_f_q && rw_s;
    wire [7:0] oe_d = !rd_cycle ? 8'h00 : wide_q ? 8'hFF : 8'hF0;

    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            drive_q <= '0;
            oe_q <= '0;
            line0_q <= '0;
            line1_q <= 7'h08;
        end else begin
            drive_q <= drive_d;
            oe_q <= oe_d;
            line0_q <= pos_addr(shift_d, split_d);
            line1_q <= pos_addr(shift_d + `LHP_HALF_OFS, split_d);
        end
    end

    assign host_bus_lines_drive = drive_q;
    assign host_bus_lines_en = oe_q;
    assign busy_flag = busy_q;
    assign line_count_select = lines_q;
    assign split_index = split_q;
    assign line0_start = line0_q;
    assign line1_start = line1_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst_all);

    a_status_word_out: assert property (
        rd_cycle && !rs_s && wide_q |=> host_bus_lines_drive == $past(status_word))
        else $error("status read does not show busy and pointer");
    a_data_read_out: assert property (
        rd_cycle && rs_s && wide_q |=> host_bus_lines_drive == $past(dhr_q))
        else $error("data read does not show data holding register");
    a_write_stores: assert property (
        wr_dat && !glyph_sel_q |=> text_q[$past(tidx_q)] == $past(host_byte))
        else $error("data write not stored in text memory");
    a_ptr_step_up: assert property (
        (wr_dat || rd_dat) && up_q && !glyph_sel_q && !split_q
        |=> ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1)
        else $error("pointer did not step up");
    a_split_wrap: assert property (
        (wr_dat || rd_dat) && split_q && up_q && !glyph_sel_q && ptr_q == `LHP_SPL_LAST
        |=> ptr_q == 7'h00)
        else $error("layout two pointer did not wrap to 00");
    a_set_addr_fetch: assert property (
        cmd == LHP_CMD_TEXT |=> ptr_q == $past(host_byte[6:0]) && dhr_q == text_q[tidx_q])
        else $error("address set did not load pointer and prefetch");
    a_read_prefetch: assert property (
        rd_dat && !glyph_sel_q |=> dhr_q == text_q[tidx_q])
        else $error("data read did not prefetch next byte");
    a_busy_hold: assert property (
        busy_start |=> busy_q [*8])
        else $error("busy flag dropped too early");
    a_bus_quiet: assert property (
        !rd_cycle |=> host_bus_lines_en == 8'h00)
        else $error("bus driven outside a read cycle");
    a_narrow_low: assert property (
        !wide_q && !$past(wide_q) |-> host_bus_lines_en[3:0] == 4'h0)
        else $error("low lines driven in 4-bit mode");
    a_shift_left_wrap: assert property (
        shift_disp && !host_byte[`LHP_SH_RIGHT_BIT] && !split_q && line0_q == `LHP_LIN_LAST
        |=> line0_q == 7'h00)
        else $error("left shift did not wrap window to 00");

    // Glyph select, refusal while busy, downward wrap, layout bit and narrow reads
    a_glyph_addr: assert property (
        cmd == LHP_CMD_GLYPH |=> glyph_sel_q && ptr_q == {2'h0, $past(host_byte[4:0])})
        else $error("glyph address set did not select glyph memory");
    a_busy_refuse: assert property (
        done && busy_q && !(rw_s && !rs_s) |=> ptr_q == $past(ptr_q) && dhr_q == $past(dhr_q))
        else $error("access taken while busy");
    a_lin_wrap_down: assert property (
        (wr_dat || rd_dat) && !up_q && !glyph_sel_q && !split_q && ptr_q[3:0] == 4'h0
        |=> ptr_q == `LHP_LIN_LAST)
        else $error("layout one pointer did not wrap to 0F");
    a_func_split: assert property (
        cmd == LHP_CMD_FUNC |=> split_index == $past(host_byte[`LHP_FN_SPLIT_BIT]))
        else $error("function set did not load split layout bit");
    a_narrow_read_en: assert property (
        rd_cycle && !wide_q |=> host_bus_lines_en == 8'hF0)
        else $error("4-bit read does not drive only upper lines");

    c_data_write: cover property (wr_dat ##[1:200] rd_dat);
    c_glyph_set: cover property (cmd == LHP_CMD_GLYPH);
    c_refused: cover property (done && busy_q && rs_s);
    c_narrow_cmd: cover property (!wide_q && wr_cmd);
    c_split_shift: cover property (split_q && shift_disp);
endmodule
